// ### common/iru_defs.vh
// Offsets, field positions and reset values of the receive interrupt unit
`ifndef IRU_DEFS_VH
`define IRU_DEFS_VH

// Bus geometry
`define IRU_ADR_W 8
`define IRU_DAT_W 32
`define IRU_CTX_N 4

// Register byte offsets
`define IRU_OFS_EVENT_SET 8'ha0
`define IRU_OFS_EVENT_CLEAR 8'ha4
`define IRU_OFS_MASK_SET 8'ha8
`define IRU_OFS_MASK_CLEAR 8'hac
`define IRU_OFS_GATE 8'hb0
`define IRU_OFS_STATUS 8'hb4
`define IRU_OFS_STATUS_MASK 8'hb8

// Field positions
`define IRU_GATE_BIT 31
`define IRU_STAT_SUMMARY_BIT 0
`define IRU_STAT_OVERRUN_BIT 1
`define IRU_STAT_W 2

// Reset values
`define IRU_EVENT_RST 4'h0
`define IRU_MASK_RST 4'h0
`define IRU_GATE_RST 1'b0
`define IRU_STAT_RST 2'h0
`define IRU_STAT_MASK_RST 2'h0
`define IRU_RDATA_RST 32'h0000_0000

`endif

// ### design/iru_edge_detect.v
// Rising-edge detector for one context interrupt signal
`timescale 1ns/1ps

module iru_edge_detect
(
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    // Level in, one-cycle pulse out
    input wire level,
    output wire rise
);

    reg prev_reg;

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            prev_reg <= 1'b0;
        else if (ce)
            prev_reg <= level;
    end

    // Held high gives one pulse only
    assign rise = level & ~prev_reg & ce;

endmodule // iru_edge_detect

// ### design/iru_top.v
// Isochronous receive context interrupt unit with a Wishbone slave
//
// Function
// - Completed input command with irq request raises signal
// - Hardware sets an event bit on rising edge only
// - Set address sets bits written one
// - Only clear-address ones clear event bits
// - Clear-address read returns events AND mask
// - Mask reads back at both; set/clear
// - Mask bit n enables context n only
// - Four event bits feed summary bit 0
// - Upper bits read zero, writes ignored, except gate bit 31
// - Global gate clear blocks external interrupt
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "iru_defs.vh"

module iru_top
(
    // Clock, reset and enable
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Receive context completion reports
    input wire [3:0] rx_cmd_done,
    input wire [3:0] rx_cmd_irq_req,
    // Interrupt outputs
    output wire receive_summary_event,
    output wire irq
);

    // Context field of a written word; only lane 0 carries it
    function [3:0] ctx_bits;
        input [31:0] data;
        input [3:0] sel;
        begin
            ctx_bits = sel[0] ? data[3:0] : 4'h0;
        end
    endfunction

    // Status field of a written word
    function [1:0] stat_bits;
        input [31:0] data;
        input [3:0] sel;
        begin
            stat_bits = sel[0] ? data[1:0] : 2'h0;
        end
    endfunction

    // Exact match only, so no alias can reach the clear addresses
    function reg_hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            reg_hit = (adr == ofs);
        end
    endfunction

    // Bus state
    reg ack_reg;
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    wire bus_req;
    wire wr_fire;

    // Register state
    reg [3:0] event_reg;
    reg [3:0] event_next;
    reg [3:0] mask_reg;
    reg [3:0] mask_next;
    reg gate_reg;
    reg gate_next;
    reg [1:0] stat_reg;
    reg [1:0] stat_next;
    reg [1:0] stat_mask_reg;
    reg [1:0] stat_mask_next;

    // Context signals
    reg [3:0] ctx_irq_reg;
    wire [3:0] ctx_rise;
    wire [3:0] masked_events;

    // Outputs
    reg summary_reg;
    reg irq_reg;

    // Write decode
    wire wr_event_set;
    wire wr_event_clr;
    wire wr_mask_set;
    wire wr_mask_clr;
    wire wr_gate;
    wire wr_stat;
    wire wr_stat_mask;

    assign bus_req = wb_cyc_i & wb_stb_i;

    // Write lands at the edge where the master sees ack
    assign wr_fire = bus_req & wb_we_i & ack_reg & ce;

    assign wr_event_set = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_EVENT_SET);
    assign wr_event_clr = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_EVENT_CLEAR);
    assign wr_mask_set = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_MASK_SET);
    assign wr_mask_clr = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_MASK_CLEAR);
    assign wr_gate = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_GATE);
    assign wr_stat = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_STATUS);
    assign wr_stat_mask = wr_fire & reg_hit(wb_adr_i, `IRU_OFS_STATUS_MASK);

    // Bus answer: data and ack together in cycle 1
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else if (ce)
            ack_reg <= bus_req & ~ack_reg;
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Read mux; unmapped offsets answer zero
    always @*
    begin
        rdata_next = `IRU_RDATA_RST;
        case (wb_adr_i)
            `IRU_OFS_EVENT_SET:
                rdata_next[3:0] = event_reg;
            `IRU_OFS_EVENT_CLEAR:
                rdata_next[3:0] = event_reg & mask_reg;
            `IRU_OFS_MASK_SET:
                rdata_next[3:0] = mask_reg;
            `IRU_OFS_MASK_CLEAR:
                rdata_next[3:0] = mask_reg;
            `IRU_OFS_GATE:
                rdata_next[`IRU_GATE_BIT] = gate_reg;
            `IRU_OFS_STATUS:
                rdata_next[1:0] = stat_reg;
            `IRU_OFS_STATUS_MASK:
                rdata_next[1:0] = stat_mask_reg;
            default:
                rdata_next = `IRU_RDATA_RST;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            rdata_reg <= `IRU_RDATA_RST;
        else if (ce && bus_req && !ack_reg && !wb_we_i)
            rdata_reg <= rdata_next;
        // Zero again from the cycle after ack, so idle data never stands
        else if (ce)
            rdata_reg <= `IRU_RDATA_RST;
    end

    // Context interrupt signal, high one cycle after each cycle that completion and irq request stand together
    always @(posedge sys_clk)
    begin
        if (!rst_n)
            ctx_irq_reg <= 4'h0;
        else if (ce)
            ctx_irq_reg <= rx_cmd_done & rx_cmd_irq_req;
    end

    // Edge detectors, one per context
    genvar i;
    generate
        for (i = 0; i < `IRU_CTX_N; i = i + 1)
        begin : g_ctx
            iru_edge_detect u_edge
            (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .ce(ce),
                .level(ctx_irq_reg[i]),
                .rise(ctx_rise[i])
            );
        end
    endgenerate

    // Event register; hardware set beats a clear in the same cycle
    always @*
    begin
        event_next = event_reg;
        if (wr_event_clr)
            event_next = event_next & ~ctx_bits(wb_dat_i, wb_sel_i);
        if (wr_event_set)
            event_next = event_next | ctx_bits(wb_dat_i, wb_sel_i);
        event_next = event_next | ctx_rise;
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            event_reg <= `IRU_EVENT_RST;
        else if (ce)
            event_reg <= event_next;
    end

    // Mask register
    always @*
    begin
        mask_next = mask_reg;
        if (wr_mask_set)
            mask_next = mask_next | ctx_bits(wb_dat_i, wb_sel_i);
        if (wr_mask_clr)
            mask_next = mask_next & ~ctx_bits(wb_dat_i, wb_sel_i);
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            mask_reg <= `IRU_MASK_RST;
        else if (ce)
            mask_reg <= mask_next;
    end

    // Global gate, written through byte lane 3
    always @*
    begin
        gate_next = gate_reg;
        if (wr_gate && wb_sel_i[3])
            gate_next = wb_dat_i[`IRU_GATE_BIT];
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            gate_reg <= `IRU_GATE_RST;
        else if (ce)
            gate_reg <= gate_next;
    end

    // Bit n of mask gates bit n of events only
    assign masked_events = event_reg & mask_reg;

    // Status: summary level and lost-edge overrun
    always @*
    begin
        stat_next = stat_reg;
        if (wr_stat)
            stat_next = stat_next & ~stat_bits(wb_dat_i, wb_sel_i);
        // Re-set every cycle the summary stands, so the line never drops
        if (|masked_events)
            stat_next[`IRU_STAT_SUMMARY_BIT] = 1'b1;
        // An edge on a bit still pending cannot be counted twice
        if (|(ctx_rise & event_reg))
            stat_next[`IRU_STAT_OVERRUN_BIT] = 1'b1;
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            stat_reg <= `IRU_STAT_RST;
        else if (ce)
            stat_reg <= stat_next;
    end

    always @*
    begin
        stat_mask_next = stat_mask_reg;
        if (wr_stat_mask)
            stat_mask_next = stat_bits(wb_dat_i, wb_sel_i);
    end

    always @(posedge sys_clk)
    begin
        if (!rst_n)
            stat_mask_reg <= `IRU_STAT_MASK_RST;
        else if (ce)
            stat_mask_reg <= stat_mask_next;
    end

    // Registered outputs; summary one cycle behind the event register, irq one cycle behind status
    always @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            summary_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            summary_reg <= |masked_events;
            irq_reg <= gate_reg & (|(stat_reg & stat_mask_reg));
        end
    end

    // Host polls event_reg after seeing this summary
    assign receive_summary_event = summary_reg;
    assign irq = irq_reg;

endmodule // iru_top

// ### sim/iru_checker.sv
// Port-level assertions for the receive interrupt unit
`timescale 1ns/1ps

module iru_checker
(
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire ce,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Context inputs and interrupt outputs
    input wire [3:0] rx_cmd_done,
    input wire [3:0] rx_cmd_irq_req,
    input wire receive_summary_event,
    input wire irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire wr_ack = wb_ack_o && wb_we_i;
    wire ctx_hit = |(rx_cmd_done & rx_cmd_irq_req);
    sequence req_seen;
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_latency: assert property (req_seen |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_cause: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    chk_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("ack outside a bus cycle");
    chk_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero while idle");
    chk_upper_bits_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[7:4] == 4'ha |->
        wb_dat_o[31:4] == 28'h0) else $error("upper bits not zero");
    chk_summary_rise_cause: assert property (
        $rose(receive_summary_event) |-> $past(ctx_hit, 3) ||
        $past(wr_ack, 2)) else $error("summary rose without cause");
    chk_summary_fall_write: assert property (
        $fell(receive_summary_event) |-> $past(wr_ack, 2))
        else $error("summary fell without a write");

    cover property (wr_ack);
    cover property ($rose(receive_summary_event));
    cover property ($rose(irq));
endmodule // iru_checker

bind iru_top iru_checker iru_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_cmd_done(rx_cmd_done), .rx_cmd_irq_req(rx_cmd_irq_req),
    .receive_summary_event(receive_summary_event), .irq(irq));

// ### sim/iru_top_tb.sv
// Self-checking bench for the receive interrupt unit
`timescale 1ns/1ps

module iru_top_tb;
    reg sys_clk = 1'b0;
    reg rst_n = 1'b0;
    reg ce = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'hf;
    reg [31:0] wb_dat_i = 32'h0;
    reg [3:0] rx_cmd_done = 4'h0;
    reg [3:0] rx_cmd_irq_req = 4'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire receive_summary_event;
    wire irq;
    integer err_total = 0;
    integer samples_checked = 0;
    integer n;
    reg [31:0] rd;

    always #25 sys_clk = ~sys_clk;

    iru_top iru_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_cmd_done(rx_cmd_done), .rx_cmd_irq_req(rx_cmd_irq_req),
        .receive_summary_event(receive_summary_event), .irq(irq));

    task print_verdict;
    begin
        if (err_total == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    task check_word(input [31:0] got, input [31:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t word %h exp %h", $time, got, exp);
        end
    end
    endtask

    task check_bit(input got, input exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t bit %b exp %b", $time, got, exp);
        end
    end
    endtask

    // Entered just after a rising edge; waits for ack under a bound
    task xfer(input we, input [7:0] a, input [31:0] d);
        integer k;
    begin
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k = k + 1)
            @(posedge sys_clk);
        if (wb_ack_o !== 1'b1)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t no ack", $time);
            print_verdict;
        end
        else
        begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
            @(posedge sys_clk);
        end
    end
    endtask

    task rd_chk(input [7:0] a, input [31:0] e);
    begin
        xfer(1'b0, a, 32'h0);
        check_word(rd, e);
    end
    endtask

    // Registered outputs lag the write by up to two edges
    task settle;
    begin
        repeat (3) @(posedge sys_clk);
    end
    endtask

    task pulse(input [3:0] done, input [3:0] req);
    begin
        rx_cmd_done <= done;
        rx_cmd_irq_req <= req;
        repeat (2) @(posedge sys_clk);
        rx_cmd_done <= 4'h0;
        rx_cmd_irq_req <= 4'h0;
        settle;
    end
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (n = 0; n < 5; n = n + 1)
            rd_chk(8'ha0 + {n[5:0], 2'b00}, 32'h0);
        xfer(1'b1, 8'ha8, 32'hffff_fff5);
        rd_chk(8'ha8, 32'h5);
        xfer(1'b1, 8'hac, 32'h1);
        rd_chk(8'hac, 32'h4);
        xfer(1'b1, 8'ha0, 32'hffff_fffa);
        xfer(1'b1, 8'ha0, 32'h0);
        rd_chk(8'ha0, 32'ha);
        rd_chk(8'ha4, 32'h0);
        check_bit(receive_summary_event, 1'b0);
        xfer(1'b1, 8'ha0, 32'h4);
        rd_chk(8'ha4, 32'h4);
        check_bit(receive_summary_event, 1'b1);
        rd_chk(8'ha0, 32'he);
        xfer(1'b1, 8'ha4, 32'h4);
        rd_chk(8'ha0, 32'ha);
        settle;
        check_bit(receive_summary_event, 1'b0);
        // Context field rides on byte lane 0 only
        wb_sel_i <= 4'he;
        xfer(1'b1, 8'ha0, 32'hffff_ffff);
        wb_sel_i <= 4'hf;
        rd_chk(8'ha0, 32'ha);
        xfer(1'b1, 8'ha4, 32'hf);
        xfer(1'b1, 8'ha8, 32'hf);
        pulse(4'hf, 4'h0);
        rd_chk(8'ha0, 32'h0);
        for (n = 0; n < 4; n = n + 1)
        begin
            pulse(4'h1 << n, 4'hf);
            rd_chk(8'ha4, (32'h2 << n) - 32'h1);
        end
        rx_cmd_done <= 4'h1;
        rx_cmd_irq_req <= 4'h1;
        settle;
        xfer(1'b1, 8'ha4, 32'hf);
        settle;
        rd_chk(8'ha0, 32'h0);
        // Summary seen plus an edge on a bit still pending
        rd_chk(8'hb4, 32'h3);
        rx_cmd_done <= 4'h0;
        xfer(1'b1, 8'ha0, 32'h2);
        xfer(1'b1, 8'hb8, 32'h1);
        settle;
        check_bit(irq, 1'b0);
        xfer(1'b1, 8'hb0, 32'h8000_0000);
        rd_chk(8'hb0, 32'h8000_0000);
        settle;
        check_bit(irq, 1'b1);
        xfer(1'b1, 8'hb8, 32'h0);
        settle;
        check_bit(irq, 1'b0);
        xfer(1'b1, 8'hb8, 32'h1);
        xfer(1'b1, 8'hac, 32'hf);
        settle;
        check_bit(receive_summary_event, 1'b0);
        xfer(1'b1, 8'hb4, 32'h3);
        rd_chk(8'hb4, 32'h0);
        settle;
        check_bit(irq, 1'b0);
        // A report made while frozen must leave no trace
        ce <= 1'b0;
        rx_cmd_done <= 4'h8;
        rx_cmd_irq_req <= 4'h8;
        settle;
        rx_cmd_done <= 4'h0;
        settle;
        ce <= 1'b1;
        @(posedge sys_clk);
        rd_chk(8'ha0, 32'h2);
        xfer(1'b1, 8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd_chk(8'hb0, 32'h0);
        rd_chk(8'ha0, 32'h0);
        print_verdict;
    end
endmodule // iru_top_tb
